// ==== src/dim_ramp.sv ====
`timescale 1ns/1ps
module dim_ramp
    import lamp_pkg::*;
#(
    parameter int DW = DIV_W
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          run,
    input  wire logic          sync_pulse,
    input  wire logic [DW-1:0] charge_div,
    input  wire logic [DW-1:0] disch_div,
    output logic      [7:0]    ramp_q,
    output phase_type          phase_q,
    output logic               disch_start,
    output logic               charge_start
);
    if (DW < 1 || DW > 32) begin : g_bad_width
        $error("dim_ramp: divider width out of range");
    end

    logic [DW-1:0] presc_q;
    logic          step;

    assign step         = presc_q == ((phase_q == CHARGE_PH) ? charge_div : disch_div);
    // Sync cuts the charge short, so the peak and the usable dimming span shrink
    assign disch_start  = run && phase_q == CHARGE_PH &&
                          (sync_pulse || (step && ramp_q == RAMP_PEAK));
    assign charge_start = run && phase_q == DISCHARGE_PH && step && ramp_q == RAMP_VALLEY;

    always_ff @(posedge clk) begin
        if (srst || !run || disch_start || charge_start || step) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + DW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            phase_q <= CHARGE_PH;
            ramp_q  <= RAMP_VALLEY;
        end else begin
            case (phase_q)
                CHARGE_PH: begin
                    if (disch_start) begin
                        phase_q <= DISCHARGE_PH;
                    end else if (step) begin
                        ramp_q <= ramp_q + 8'h01;
                    end
                end
                DISCHARGE_PH: begin
                    if (charge_start) begin
                        phase_q <= CHARGE_PH;
                    end else if (step) begin
                        ramp_q <= ramp_q - 8'h01;
                    end
                end
                default: phase_q <= CHARGE_PH;
            endcase
        end
    end

    ramp_bounds_a: assert property (@(posedge clk) disable iff (srst)
        ramp_q >= RAMP_VALLEY && ramp_q <= RAMP_PEAK)
        else $error("ramp left valley-to-peak span");
    peak_turn_a: assert property (@(posedge clk) disable iff (srst)
        (run && phase_q == CHARGE_PH && step && ramp_q == RAMP_PEAK) ##1 run
        |-> phase_q == DISCHARGE_PH && ramp_q == RAMP_PEAK)
        else $error("ramp did not turn at peak");
    free_run_a: assert property (@(posedge clk) disable iff (srst)
        (run && phase_q == DISCHARGE_PH && step && ramp_q == RAMP_VALLEY) ##1 run
        |-> phase_q == CHARGE_PH)
        else $error("ramp did not restart charge at valley");
    sync_cut_a: assert property (@(posedge clk) disable iff (srst)
        (run && sync_pulse && phase_q == CHARGE_PH) ##1 run |-> phase_q == DISCHARGE_PH)
        else $error("sync pulse did not end charge");

endmodule : dim_ramp

// ==== src/lamp_dimming_startup_fault_logic.sv ====
// Function
// - Dimming output turns on at discharge start, off when falling ramp meets reference.
// - Reference below valley keeps output on until next charge phase starts.
// - Ramp rises valley to peak while charging, falls back while discharging.
// - Without sync the dimming oscillator free-runs on programmed phase lengths.
// - A sync pulse ends the charge phase at once and starts discharge.
// - Under sync the usable reference span shrinks since the ramp peak is cut.
// - Logic idle below first mode threshold; drivers enabled only past the second.
// - Open-lamp detector held off between driver enable and its own threshold.
// - Enabled detector counts up each tank cycle with a deep supply dip.
// - Detector counts down each tank cycle without such a dip.
// - Counter reaching sixteen declares open-lamp fault and stops both drivers.
// - Open-lamp fault stays latched until a full power cycle.
// - Sync level at dimming enable picks digital or analog reference use.
// - Digital mode: reference high enables lamp drivers, low disables them.
// - Open-lamp detector becomes active only past the third mode threshold.
// - Low-rate dimming becomes active only past the fourth mode threshold.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module lamp_dimming_startup_fault_logic
    import lamp_pkg::*;
#(
    parameter int DW = DIV_W
) (
    input  wire logic              clk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Comparator pins
    input  wire logic [3:0]        mode_level_above,
    input  wire logic              dimming_sync_input,
    input  wire logic              dimming_reference,
    input  wire logic              tank_sense_a,
    input  wire logic              tank_sense_b,
    input  wire logic              tank_cycle_a,
    input  wire logic              tank_cycle_b,
    // Drivers and status
    output logic                   fet_drive_a,
    output logic                   fet_drive_b,
    output logic                   dim_pwm,
    output logic                   open_lamp_fault
);
    if (DW < 1 || DW > 32) begin : g_bad_width
        $error("lamp logic: divider width out of range");
    end

    localparam int PIN_W  = 10;
    localparam int P_SYNC = 4;
    localparam int P_REF  = 5;
    localparam int P_DIP  = 6;
    localparam int P_CYC  = 8;

    // Pin synchronisers; only stage two and three are read
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic [PIN_W-1:0] pin_s3_q;
    logic [PIN_W-1:0] pin_raw;

    assign pin_raw = {tank_cycle_b, tank_cycle_a, tank_sense_b, tank_sense_a,
                      dimming_reference, dimming_sync_input, mode_level_above};

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic                sync_level;
    logic                sync_rise;
    logic                ref_level;
    logic [CHANNELS-1:0] dip;
    logic [CHANNELS-1:0] cyc_rise;

    assign sync_level = pin_s2_q[P_SYNC];
    assign sync_rise  = pin_s2_q[P_SYNC] & ~pin_s3_q[P_SYNC];
    assign ref_level  = pin_s2_q[P_REF];
    assign dip        = pin_s2_q[P_DIP +: CHANNELS];
    assign cyc_rise   = pin_s2_q[P_CYC +: CHANNELS] & ~pin_s3_q[P_CYC +: CHANNELS];

    // Start-up staging from the mode level comparators
    stage_type stage;

    always_comb begin
        stage.active    = pin_s2_q[MODE_ACTIVE];
        stage.drive     = stage.active & pin_s2_q[MODE_DRIVE];
        stage.open_lamp = stage.drive & pin_s2_q[MODE_OPEN];
        stage.dim       = stage.drive & pin_s2_q[MODE_DIM];
    end

    // Registers
    logic [DW-1:0] charge_div_q;
    logic [DW-1:0] disch_div_q;
    logic [7:0]    dim_code_q;
    logic          wr_en;
    logic          setup;
    logic          addr_ok;
    logic          rd_only;

    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite & addr_ok & ~rd_only;
    assign addr_ok = paddr == CHARGE_OFF || paddr == DISCH_OFF ||
                     paddr == DIM_OFF || paddr == STATUS_OFF;
    assign rd_only = paddr == STATUS_OFF;

    always_ff @(posedge clk) begin
        if (srst) begin
            charge_div_q <= DW'(CHARGE_RST);
            disch_div_q  <= DW'(DISCH_RST);
            dim_code_q   <= DIM_RST;
        end else if (wr_en) begin
            if (paddr == CHARGE_OFF) begin
                charge_div_q <= pwdata[DW-1:0];
            end
            if (paddr == DISCH_OFF) begin
                disch_div_q <= pwdata[DW-1:0];
            end
            if (paddr == DIM_OFF) begin
                dim_code_q <= pwdata[7:0];
            end
        end
    end

    // Dimming mode, caught as the dimming stage is entered
    logic dim_en_q;
    logic digital_mode_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            dim_en_q       <= 1'b0;
            digital_mode_q <= 1'b0;
        end else begin
            dim_en_q <= stage.dim;
            // Re-armed on every rise, so a new mode needs the level dropped first
            if (stage.dim && !dim_en_q) begin
                digital_mode_q <= sync_level;
            end
        end
    end

    // Oscillator and dimming comparator
    logic       osc_run;
    logic [7:0] ramp;
    phase_type  phase;
    logic       disch_start;
    logic       charge_start;
    logic       fault_q;

    assign osc_run = stage.dim & ~digital_mode_q & ~fault_q;

    dim_ramp #(
        .DW           (DW)
    ) u_ramp (
        .clk          (clk),
        .srst         (srst),
        .run          (osc_run),
        .sync_pulse   (sync_rise),
        .charge_div   (charge_div_q),
        .disch_div    (disch_div_q),
        .ramp_q       (ramp),
        .phase_q      (phase),
        .disch_start  (disch_start),
        .charge_start (charge_start)
    );

    logic pwm_q;

    always_ff @(posedge clk) begin
        if (srst || !osc_run) begin
            pwm_q <= 1'b0;
        end else if (disch_start) begin
            pwm_q <= 1'b1;
        end else if (charge_start) begin
            pwm_q <= 1'b0;
        end else if (phase == DISCHARGE_PH && ramp <= dim_code_q) begin
            pwm_q <= 1'b0;
        end
    end

    // Open-lamp detection, one counter per channel
    logic [CHANNELS-1:0]           terminal;
    logic [CHANNELS-1:0][OL_W-1:0] ol_count;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ol
        open_lamp_counter u_ol (
            .clk        (clk),
            .srst       (srst),
            .enable     (stage.open_lamp & ~fault_q),
            .tank_cycle (cyc_rise[ch]),
            .tank_dip   (dip[ch]),
            .count_q    (ol_count[ch]),
            .terminal   (terminal[ch])
        );
    end

    // Only the power-on reset clears the fault
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_q <= 1'b0;
        end else if (|terminal) begin
            fault_q <= 1'b1;
        end
    end

    // Driver gate shared by both channels
    logic dim_gate;
    logic drive_on;
    logic drive_a_q;
    logic drive_b_q;

    always_comb begin
        if (!stage.dim) begin
            dim_gate = 1'b1;
        end else if (digital_mode_q) begin
            dim_gate = ref_level;
        end else begin
            dim_gate = pwm_q;
        end
    end

    assign drive_on = stage.drive & ~fault_q & dim_gate;

    always_ff @(posedge clk) begin
        if (srst) begin
            drive_a_q <= 1'b0;
            drive_b_q <= 1'b0;
        end else begin
            drive_a_q <= drive_on;
            drive_b_q <= drive_on;
        end
    end

    assign fet_drive_a     = drive_a_q;
    assign fet_drive_b     = drive_b_q;
    assign dim_pwm         = pwm_q;
    assign open_lamp_fault = fault_q;

    // Read path registered in the setup cycle; access phase never waits
    status_type status;
    logic [31:0] rdata_q;
    logic        err_q;

    always_comb begin
        status.ramp         = ramp;
        status.count_b      = ol_count[1];
        status.count_a      = ol_count[0];
        status.zero         = '0;
        status.fault        = fault_q;
        status.digital_mode = digital_mode_q;
        status.pwm          = pwm_q;
        status.discharging  = phase == DISCHARGE_PH;
        status.stage        = stage;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else if (setup) begin
            err_q <= ~addr_ok | (pwrite & rd_only);
            case (paddr)
                CHARGE_OFF: rdata_q <= 32'(charge_div_q);
                DISCH_OFF:  rdata_q <= 32'(disch_div_q);
                DIM_OFF:    rdata_q <= {24'h00_0000, dim_code_q};
                STATUS_OFF: rdata_q <= status;
                default:    rdata_q <= '0;
            endcase
        end
    end

    assign pready  = psel & penable;
    assign pslverr = psel & penable & err_q;
    assign prdata  = rdata_q;

    pwm_on_a: assert property (@(posedge clk) disable iff (srst)
        disch_start |=> pwm_q && phase == DISCHARGE_PH)
        else $error("pwm not on at discharge start");
    pwm_off_a: assert property (@(posedge clk) disable iff (srst)
        (osc_run && !disch_start && phase == DISCHARGE_PH && ramp <= dim_code_q) |=> !pwm_q)
        else $error("pwm not off at reference crossing");
    valley_hold_a: assert property (@(posedge clk) disable iff (srst)
        (osc_run && pwm_q && dim_code_q < RAMP_VALLEY && !charge_start) ##1 osc_run
        |-> pwm_q)
        else $error("pwm dropped before charge with low reference");
    stage_gate_a: assert property (@(posedge clk) disable iff (srst)
        !stage.drive |=> !fet_drive_a && !fet_drive_b)
        else $error("drivers on below driver threshold");
    fault_stop_a: assert property (@(posedge clk) disable iff (srst)
        |terminal |=> fault_q ##1 (!fet_drive_a && !fet_drive_b))
        else $error("terminal count did not stop drivers");
    fault_hold_a: assert property (@(posedge clk) disable iff (srst)
        fault_q |=> fault_q)
        else $error("open-lamp fault cleared without reset");
    mode_catch_a: assert property (@(posedge clk) disable iff (srst)
        $rose(stage.dim) |=> digital_mode_q == $past(sync_level))
        else $error("dimming mode not taken from sync level");
    digital_gate_a: assert property (@(posedge clk) disable iff (srst)
        (stage.dim && digital_mode_q && !fault_q) |=> fet_drive_a == $past(ref_level))
        else $error("digital reference not steering drivers");
    dim_stage_a: assert property (@(posedge clk) disable iff (srst)
        (stage.drive && !stage.dim && !fault_q) |=> fet_drive_a && !pwm_q)
        else $error("dimming active below its threshold");

endmodule : lamp_dimming_startup_fault_logic

// ==== src/lamp_pkg.sv ====
package lamp_pkg;

    // Ramp codes: valley and peak of the dimming ramp
    localparam int             RAMP_W      = 8;
    localparam logic [7:0]     RAMP_VALLEY = 8'h01;
    localparam logic [7:0]     RAMP_PEAK   = 8'hFF;

    // Step divider of the ramp, one ramp step per (divider + 1) clocks
    localparam int             DIV_W       = 16;
    localparam logic [15:0]    CHARGE_RST  = 16'h0100;
    localparam logic [15:0]    DISCH_RST   = 16'h0080;
    localparam logic [7:0]     DIM_RST     = 8'h80;

    // Open-lamp up/down counter
    localparam int             OL_W        = 4;
    localparam logic [3:0]     OL_TERMINAL = 4'hF;
    localparam logic [3:0]     OL_ZERO     = 4'h0;
    localparam int             CHANNELS    = 2;

    // Comparator bits of the mode level, in order of rising threshold
    localparam int             MODE_ACTIVE = 0;
    localparam int             MODE_DRIVE  = 1;
    localparam int             MODE_OPEN   = 2;
    localparam int             MODE_DIM    = 3;

    // APB register map (byte addresses)
    localparam int             ADDR_W      = 8;
    localparam logic [7:0]     CHARGE_OFF  = 8'h00;
    localparam logic [7:0]     DISCH_OFF   = 8'h04;
    localparam logic [7:0]     DIM_OFF     = 8'h08;
    localparam logic [7:0]     STATUS_OFF  = 8'h0C;

    typedef enum logic {CHARGE_PH, DISCHARGE_PH} phase_type;

    typedef struct packed {
        logic dim;
        logic open_lamp;
        logic drive;
        logic active;
    } stage_type;

    typedef struct packed {
        logic [7:0] ramp;
        logic [3:0] count_b;
        logic [3:0] count_a;
        logic [7:0] zero;
        logic       fault;
        logic       digital_mode;
        logic       pwm;
        logic       discharging;
        stage_type  stage;
    } status_type;

endpackage : lamp_pkg

// ==== src/open_lamp_counter.sv ====
`timescale 1ns/1ps
module open_lamp_counter
    import lamp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            enable,
    input  wire logic            tank_cycle,
    input  wire logic            tank_dip,
    output logic      [OL_W-1:0] count_q,
    output logic                 terminal
);
    // Sixteenth dip would wrap the 4-bit count, so it is the terminal event
    assign terminal = enable && tank_cycle && tank_dip && count_q == OL_TERMINAL;

    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            count_q <= OL_ZERO;
        end else if (tank_cycle) begin
            if (tank_dip) begin
                if (count_q != OL_TERMINAL) begin
                    count_q <= count_q + 4'h1;
                end
            end else if (count_q != OL_ZERO) begin
                count_q <= count_q - 4'h1;
            end
        end
    end

    ol_idle_a: assert property (@(posedge clk) disable iff (srst)
        !enable |=> count_q == OL_ZERO)
        else $error("open-lamp count moved while disabled");
    ol_up_a: assert property (@(posedge clk) disable iff (srst)
        (enable && tank_cycle && tank_dip && count_q != OL_TERMINAL) ##1 enable
        |-> count_q == $past(count_q) + 4'h1)
        else $error("open-lamp count did not rise on a dip");
    ol_down_a: assert property (@(posedge clk) disable iff (srst)
        (enable && tank_cycle && !tank_dip && count_q != OL_ZERO) ##1 enable
        |-> count_q == $past(count_q) - 4'h1)
        else $error("open-lamp count did not fall without a dip");

endmodule : open_lamp_counter

// ==== test/ctrl_model.sv ====
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic       clk,
    output logic      [3:0] mode_level_above,
    output logic            dimming_sync_input,
    output logic            dimming_reference
);
    initial begin
        mode_level_above   = 4'h0;
        dimming_sync_input = 1'b0;
        dimming_reference  = 1'b0;
    end
    // Mode bits form a cumulative ladder, like a charging capacitor
    task automatic stage(input int n);
        @(posedge clk);
        mode_level_above <= 4'((1 << n) - 1);
    endtask : stage
    // Sync held steady while mode crosses the dimming threshold
    task automatic pick_mode(input logic digital);
        stage(3);
        repeat (8) @(posedge clk);
        dimming_sync_input <= digital;
        repeat (8) @(posedge clk);
        stage(4);
    endtask : pick_mode
    // One lone pulse, far below the sync rate ceiling
    task automatic sync_pulse();
        @(posedge clk);
        dimming_sync_input <= 1'b1;
        repeat (4) @(posedge clk);
        dimming_sync_input <= 1'b0;
    endtask : sync_pulse
    task automatic set_ref(input logic v);
        @(posedge clk);
        dimming_reference <= v;
    endtask : set_ref
endmodule : ctrl_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
    import lamp_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  mode_level_above;
    logic        dimming_sync_input, dimming_reference;
    logic        tank_sense_a, tank_sense_b, tank_cycle_a, tank_cycle_b;
    logic        fet_drive_a, fet_drive_b, dim_pwm, open_lamp_fault;
    int          bad_count, n_tests, cycles, cnt;

    lamp_dimming_startup_fault_logic i_lamp_dimming_startup_fault_logic (
        .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mode_level_above, .dimming_sync_input, .dimming_reference,
        .tank_sense_a, .tank_sense_b, .tank_cycle_a, .tank_cycle_b,
        .fet_drive_a, .fet_drive_b, .dim_pwm, .open_lamp_fault);
    ctrl_model i_ctrl_model (.clk, .mode_level_above, .dimming_sync_input,
        .dimming_reference);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Whole run is a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int t;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1'b1, pready);
    endtask : apb

    task automatic go(input int n);
        i_ctrl_model.stage(n);
        repeat (6) @(posedge clk);
        apb(1'b0, STATUS_OFF, 32'h0000_0000);
    endtask : go

    // Pulse width and settle time measured at the falling edge
    task automatic wait_pwm(input logic v, input int lim);
        cnt = 0;
        @(negedge clk);
        while (dim_pwm !== v && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
        chk("dim_pwm", v, dim_pwm);
    endtask : wait_pwm

    // Dip set a clock ahead so it is settled when the cycle edge lands
    task automatic tank(input logic b, input logic dip, input int n);
        repeat (n) begin
            @(posedge clk);
            tank_sense_a <= dip & !b;
            tank_sense_b <= dip & b;
            @(posedge clk);
            tank_cycle_a <= !b;
            tank_cycle_b <= b;
            repeat (4) @(posedge clk);
            tank_cycle_a <= 1'b0;
            tank_cycle_b <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        apb(1'b0, STATUS_OFF, 32'h0000_0000);
    endtask : tank

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {tank_sense_a, tank_sense_b, tank_cycle_a, tank_cycle_b} = 4'h0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, CHARGE_OFF, 32'h0000_0000);
        chk("charge", 32'(CHARGE_RST), rd);
        apb(1'b0, DISCH_OFF, 32'h0000_0000);
        chk("disch", 32'(DISCH_RST), rd);
        apb(1'b0, DIM_OFF, 32'h0000_0000);
        chk("dim", 32'(DIM_RST), rd);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 33'h1_0000_0000, {err, rd});
        apb(1'b1, STATUS_OFF, 32'hFFFF_FFFF);
        chk("ro_status", 1'b1, err);
        go(0);
        chk("stage0", 6'h00, {fet_drive_a, fet_drive_b, rd[3:0]});
        go(1);
        chk("stage1", 6'h01, {fet_drive_a, fet_drive_b, rd[3:0]});
        go(2);
        chk("stage2", 6'h33, {fet_drive_a, fet_drive_b, rd[3:0]});
        tank(1'b0, 1'b1, 3);
        chk("held_count", 4'h0, rd[19:16]);
        go(3);
        chk("stage3", 4'h7, rd[3:0]);
        tank(1'b0, 1'b1, 3);
        chk("count_up", 4'h3, rd[19:16]);
        tank(1'b0, 1'b0, 1);
        chk("count_down", 4'h2, rd[19:16]);
        apb(1'b1, CHARGE_OFF, 32'h0000_0000);
        apb(1'b1, DISCH_OFF, 32'h0000_0000);
        apb(1'b1, DIM_OFF, 32'h0000_0080);
        go(4);
        chk("analog", 5'h0F, {rd[6], rd[3:0]});
        // Step per clock: 127 steps down to code 0x80, then 127 down to the valley and 254 up
        wait_pwm(1'b1, 800);
        wait_pwm(1'b0, 300);
        chk("pwm_high", 1'b1, cnt inside {[125:130]});
        wait_pwm(1'b1, 800);
        chk("pwm_low", 1'b1, cnt inside {[376:386]});
        apb(1'b1, DIM_OFF, 32'h0000_0000);
        wait_pwm(1'b1, 800);
        wait_pwm(1'b0, 600);
        chk("below_valley", 1'b1, cnt inside {[250:258]});
        apb(1'b1, CHARGE_OFF, 32'h0000_0003);
        wait_pwm(1'b1, 1500);
        wait_pwm(1'b0, 600);
        repeat (20) @(posedge clk);
        i_ctrl_model.sync_pulse();
        // Charge would otherwise run about a thousand clocks
        wait_pwm(1'b1, 10);
        i_ctrl_model.pick_mode(1'b1);
        i_ctrl_model.set_ref(1'b1);
        go(4);
        chk("digital_on", 3'h7, {rd[6], fet_drive_a, fet_drive_b});
        i_ctrl_model.set_ref(1'b0);
        repeat (6) @(posedge clk);
        chk("digital_off", 2'h0, {fet_drive_a, fet_drive_b});
        go(3);
        chk("gate_open", 2'h3, {fet_drive_a, fet_drive_b});
        tank(1'b1, 1'b1, 15);
        chk("count_15", 6'h3E, {fet_drive_a, rd[23:20], rd[7]});
        tank(1'b1, 1'b1, 1);
        chk("fault", 3'h4, {open_lamp_fault, fet_drive_a, fet_drive_b});
        go(0);
        chk("latched", 1'b1, open_lamp_fault);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("power_cycle", 3'h0, {open_lamp_fault, fet_drive_a, fet_drive_b});
        print_verdict();
    end
endmodule : tb
